// ---- verilog/lfre_tag.sv ----
// Purpose: Control logic of a passive LF tag: modes, bit timing, programming
// Assumes: ref_clk is recovered from the carrier; reset_n is power-on reset
// Notes:   Array storage and high voltages live outside this block
`timescale 1ns/1ns
module lfre_tag (
	// Clock and power-on reset
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	// Factory configuration and field sense
	input  wire logic [lfre_pkg::CFG_W-1:0] factoryCfg,
	input  wire logic                      fieldPresent,
	// Array port
	output logic      [6:0]                arrayAddr,
	input  wire logic                      arrayData,
	output logic                           progWrite,
	output logic                           progData,
	// Demodulated reader programming bit
	input  wire logic                      rxBit,
	// Antenna and status
	output logic                           dampSwitch,
	output logic      [lfre_pkg::CFG_W-1:0] cfgWord,
	output logic                           arrayLockFlag,
	output logic                           nativeMode,
	output logic                           progMode
);
	import lfre_pkg::*;

	lfre_sym_if sym ();

	lfre_state_t state;      // Control state
	lfre_state_t next_state; // Following state
	logic [CFG_W-1:0] cfg;   // Captured factory word
	logic       lock;        // Lock flag
	logic [7:0] cycCnt;      // Carrier cycle within bit
	logic [7:0] bitIdx;      // Bit within stream
	logic       bitStart;    // Bit strobe to modulator
	logic       halfStart;   // Half strobe to modulator
	logic       dataBit;     // Bit to modulator
	logic       rxSample;    // Reader bit taken mid-period
	logic       damp;        // Registered antenna drive

	// Option selection; unlocked tag ignores all of the word but length_select
	wire        native   = ~lock;
	wire [2:0]  rateSel  = cfg[CFG_RATE_LSB +: 3];
	wire [7:0]  period   = native ? RATE_DIV_DEFAULT : RATE_DIV_TABLE[rateSel];
	wire [7:0]  halfPt   = {1'b0, period[7:1]};
	wire [7:0]  streamLen = (state == ST_READ || state == ST_NATIVE) ?
		(cfg[CFG_LEN_BIT] ? LEN_LONG : LEN_SHORT) : PROG_BITS;
	wire        bitEnd   = cycCnt == period - 8'h01;
	wire        lastBit  = bitIdx == streamLen - 8'h01;
	wire        runs     = state != ST_INIT && state != ST_GAP;

	// Encoding and modulation; native forces FSK and NRZ_L
	assign sym.encSel    = native ? ENC_NRZ : cfg[CFG_ENC_LSB +: 2];
	assign sym.modSel    = native ? MOD_FSK : cfg[CFG_MOD_LSB +: 2];
	assign sym.bitStart  = bitStart;
	assign sym.halfStart = halfStart;
	assign sym.dataBit   = dataBit;

	lfre_modulator u_mod (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.sym     (sym)
	);

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			// Lock register is only loaded on this edge, so read the word itself
			ST_INIT:   next_state = factoryCfg[CFG_LOCK_BIT] ? ST_READ : ST_NATIVE;
			ST_NATIVE: if (!fieldPresent)
					next_state = ST_GAP;       // Gap after power-up
			ST_GAP:    if (fieldPresent)
					next_state = ST_BLANK;
			ST_BLANK:  if (!fieldPresent)
					next_state = ST_GAP;
				else if (bitEnd && lastBit)
					next_state = ST_PROG;
			ST_PROG:   if (!fieldPresent)
					next_state = ST_READ;
				else if (bitEnd && lastBit)
					next_state = ST_ECHO;
			ST_ECHO:   if (!fieldPresent)
					next_state = ST_READ;
				else if (bitEnd && lastBit)
					next_state = ST_PROG;      // Reader may repeat pass
			default:   next_state = ST_READ;
		endcase
	end

	// State and lock; the word is caught once after reset
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state <= ST_INIT;
			cfg   <= '0;
			lock  <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_INIT) begin
				cfg  <= factoryCfg;
				lock <= factoryCfg[CFG_LOCK_BIT];
			end else if ((state == ST_PROG || state == ST_ECHO) && !fieldPresent)
				lock <= 1'b1;
		end
	end

	// Carrier cycle counter sets every bit period
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			cycCnt <= 8'h00;
		else if (!runs || state != next_state || bitEnd)
			cycCnt <= 8'h00;
		else
			cycCnt <= cycCnt + 8'h01;
	end

	// Bit index steps at bit rate and wraps
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			bitIdx <= 8'h00;
		else if (!runs || state != next_state)
			bitIdx <= 8'h00;
		else if (bitEnd)
			bitIdx <= lastBit ? 8'h00 : bitIdx + 8'h01;
	end

	// Array address follows the bit index, bit 1 is address 0
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			arrayAddr <= 7'h00;
		else
			arrayAddr <= bitIdx[6:0];
	end

	// Strobes and data to the modulator; blank check sends ones
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			bitStart  <= 1'b0;
			halfStart <= 1'b0;
			dataBit   <= 1'b0;
		end else begin
			bitStart  <= runs && cycCnt == 8'h01;
			// Offset by one like the bit strobe so both halves are equal
			halfStart <= runs && cycCnt == halfPt + 8'h01;
			if (runs && cycCnt == 8'h01)
				dataBit <= (state == ST_BLANK) ? 1'b1 :
					(state == ST_PROG) ? 1'b0 : arrayData;
		end
	end

	// Programming: sample mid-bit, write at bit end, only while unlocked
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rxSample  <= 1'b0;
			progWrite <= 1'b0;
			progData  <= 1'b0;
		end else begin
			if (state == ST_PROG && cycCnt == halfPt)
				rxSample <= rxBit;
			progWrite <= state == ST_PROG && bitEnd && !lock && fieldPresent;
			if (state == ST_PROG && bitEnd)
				progData <= rxSample;
		end
	end

	// Status outputs; zero bit forced, lock shown in MSB
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfgWord       <= '0;
			arrayLockFlag <= 1'b0;
			nativeMode    <= 1'b1;
			progMode      <= 1'b0;
			damp          <= 1'b0;
		end else begin
			cfgWord       <= {lock, 1'b0, cfg[CFG_ZERO_BIT-1:0]};
			arrayLockFlag <= lock;
			nativeMode    <= native;
			progMode      <= state == ST_PROG;
			damp          <= runs ? sym.damp : 1'b0; // Quiet in ST_INIT and ST_GAP
		end
	end

	assign dampSwitch = damp;

endmodule : lfre_tag

// ---- verilog/lfre_pkg.sv ----
// Purpose: Shared constants for the LF tag encoder and modulator
// Assumes: ref_clk is the clock recovered from the reader carrier
// Notes:   Option codes are localparams here so they are easy to change
// Function
// - Configuration word fixed, never written contactlessly
// - fixed_zero_bit always reads as zero
// - Lock zero to program, then blocks forever
// - rate_select bits set bit period; 110 gives 32
// - Unlocked tag uses carrier/128, FSK, NRZ_L
// - encode_select picks NRZ_L, biphase, Manchester, inverted
// - modulation_select picks ASK, FSK, two phase shifts
// - ASK drives damping switch with encoded stream
// - FSK high: 10-cycle groups, 5 undamped, 5 damped
// - FSK low: 8-cycle groups, 4 undamped, 4 damped
// - Whole FSK groups per bit period; code restarts groups each bit, last one cut short
// - Phase inverts whenever encoded value changes
// - Phase inverts on every encoded one
// - length_select chooses 96 or 128 bits
// - Array addressed serially at bit rate, 1..128
// - Word MSB is lock flag, LSB length_select
// - Locked tag reads out with configured options
// - Blank tag answers gap with 128 FSK ones
// - Programming follows blank check, 128 cycles per bit
// - Tag echoes data after each programming pass
// - Field loss in programming sets lock flag
// - All timing counted on carrier-derived clock
// - Held in reset until supply is sufficient
package lfre_pkg;

	// Configuration word fields, MSB lock, LSB length
	localparam int CFG_W          = 12;
	localparam int CFG_LEN_BIT    = 0;
	localparam int CFG_RATE_LSB   = 1;
	localparam int CFG_ENC_LSB    = 5;
	localparam int CFG_MOD_LSB    = 7;
	localparam int CFG_ZERO_BIT   = 10;
	localparam int CFG_LOCK_BIT   = 11;

	// Stream lengths in bits
	localparam logic [7:0] LEN_SHORT    = 8'h60;
	localparam logic [7:0] LEN_LONG     = 8'h80;
	localparam logic [7:0] BLANK_BITS   = 8'h80;
	localparam logic [7:0] PROG_BITS    = 8'h80;

	// Carrier cycles per bit, indexed by rate_select
	localparam logic [7:0] RATE_DIV_DEFAULT = 8'h80;
	localparam logic [7:0] RATE_DIV_TABLE [0:7] = '{
		8'h80, 8'h64, 8'h50, 8'h40, 8'h28, 8'h32, 8'h20, 8'h10};

	// Encoding codes
	localparam logic [1:0] ENC_NRZ     = 2'h0;
	localparam logic [1:0] ENC_DIFF    = 2'h1;
	localparam logic [1:0] ENC_MAN     = 2'h2;
	localparam logic [1:0] ENC_MAN_INV = 2'h3;

	// Modulation codes
	localparam logic [1:0] MOD_FSK     = 2'h0;
	localparam logic [1:0] MOD_ASK     = 2'h1;
	localparam logic [1:0] MOD_PSK_CHG = 2'h2;
	localparam logic [1:0] MOD_PSK_ONE = 2'h3;

	// FSK group lengths and undamped halves
	localparam logic [3:0] FSK_HI_GROUP = 4'ha;
	localparam logic [3:0] FSK_HI_HALF  = 4'h5;
	localparam logic [3:0] FSK_LO_GROUP = 4'h8;
	localparam logic [3:0] FSK_LO_HALF  = 4'h4;

	// Control states
	typedef enum logic [2:0] {
		ST_INIT, ST_NATIVE, ST_GAP, ST_BLANK, ST_PROG, ST_ECHO, ST_READ
	} lfre_state_t;

endpackage : lfre_pkg

// ---- verilog/lfre_sym_if.sv ----
// Purpose: Carries bit timing and data from control to modulator
// Assumes: One clock domain
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/1ns
interface lfre_sym_if;
	logic       bitStart;  // First cycle of a data bit
	logic       halfStart; // First cycle of second half bit
	logic       dataBit;   // Bit to send, valid with bitStart
	logic [1:0] encSel;    // Encoding choice
	logic [1:0] modSel;    // Modulation choice
	logic       damp;      // Damping switch drive

	modport ctrl (output bitStart, output halfStart, output dataBit,
		output encSel, output modSel, input damp);
	modport modu (input bitStart, input halfStart, input dataBit,
		input encSel, input modSel, output damp);
endinterface : lfre_sym_if

// ---- verilog/lfre_modulator.sv ----
// Purpose: Encodes serial bits and modulates the damping switch
// Assumes: Strobes come from the bit timer in the control block
// Notes:   Two cycles of latency from strobe to switch
`timescale 1ns/1ns
module lfre_modulator (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Symbol stream
	lfre_sym_if.modu  sym
);
	import lfre_pkg::*;

	logic       encLvl;   // Current encoded level
	logic       phase;    // PSK phase state
	logic       sub;      // PSK subcarrier, toggles each cycle
	logic [3:0] fskCnt;   // Position in current FSK group
	logic       damp;     // Registered switch drive
	logic       next_enc; // Encoded level after this cycle
	wire        symEvt    = sym.bitStart | sym.halfStart;
	wire  [3:0] grpLen    = encLvl ? FSK_HI_GROUP : FSK_LO_GROUP;
	wire  [3:0] grpHalf   = encLvl ? FSK_HI_HALF : FSK_LO_HALF;

	// Half-bit encoders; biphase gives two symbols per bit
	always_comb begin
		next_enc = encLvl;
		if (sym.bitStart) begin
			case (sym.encSel)
				ENC_NRZ:  next_enc = sym.dataBit;
				ENC_DIFF: next_enc = ~encLvl;    // Edge at every bit start
				ENC_MAN:  next_enc = sym.dataBit;
				default:  next_enc = ~sym.dataBit;
			endcase
		end else if (sym.halfStart) begin
			case (sym.encSel)
				ENC_NRZ:  next_enc = encLvl;
				ENC_DIFF: next_enc = sym.dataBit ? encLvl : ~encLvl; // Mid edge on zero
				default:  next_enc = ~encLvl;   // Manchester flips mid-bit
			endcase
		end
	end

	// Encoder and PSK state
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			encLvl <= 1'b0;
			phase  <= 1'b0;
			sub    <= 1'b0;
		end else begin
			encLvl <= next_enc;
			sub    <= ~sub;
			if (sym.modSel == MOD_PSK_CHG && symEvt && next_enc != encLvl)
				phase <= ~phase;
			else if (sym.modSel == MOD_PSK_ONE && sym.bitStart && next_enc)
				phase <= ~phase;
		end
	end

	// FSK group counter; restarts each bit so every bit starts with a whole group
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			fskCnt <= 4'h0;
		else if (symEvt && next_enc != encLvl)
			fskCnt <= 4'h0;
		else if (sym.bitStart)
			fskCnt <= 4'h0;
		else if (fskCnt == grpLen - 4'h1)
			fskCnt <= 4'h0;
		else
			fskCnt <= fskCnt + 4'h1;
	end

	// Switch drive per modulation choice
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			damp <= 1'b0;
		else case (sym.modSel)
			MOD_ASK: damp <= encLvl;
			MOD_FSK: damp <= fskCnt >= grpHalf;
			default: damp <= sub ^ phase;
		endcase
	end

	assign sym.damp = damp;

endmodule : lfre_modulator

// ---- dv/lfre_tag_properties.sv ----
// Purpose: Port-level checks of the tag control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Run counter saturates so long holds cannot wrap
`timescale 1ns/1ns
module lfre_tag_properties (
	// Clock and reset
	input wire logic                       ref_clk,
	input wire logic                       reset_n,
	// Configuration and field
	input wire logic [lfre_pkg::CFG_W-1:0] factoryCfg,
	input wire logic                       fieldPresent,
	// Array port
	input wire logic [6:0]                 arrayAddr,
	input wire logic                       arrayData,
	input wire logic                       progWrite,
	input wire logic                       progData,
	input wire logic                       rxBit,
	// Antenna and status
	input wire logic                       dampSwitch,
	input wire logic [lfre_pkg::CFG_W-1:0] cfgWord,
	input wire logic                       arrayLockFlag,
	input wire logic                       nativeMode,
	input wire logic                       progMode
);
	import lfre_pkg::*;
	logic [3:0] dampRun; // Cycles of unbroken damping
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Count damped run, saturating at 15
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !dampSwitch) dampRun <= 4'h0;
		else if (dampRun != 4'hf) dampRun <= dampRun + 4'h1;
	end
	// Field lost while a programming pass runs
	sequence sFieldDrop;
		progMode ##1 !fieldPresent;
	endsequence
	AST_ZERO_BIT: assert property (cfgWord[10] == 1'b0)
		else $error("fixed zero bit reads one");
	AST_LOCK_STICKY: assert property (arrayLockFlag |=> arrayLockFlag)
		else $error("lock flag cleared");
	AST_NO_WRITE_LOCKED: assert property (arrayLockFlag |-> !progWrite)
		else $error("write while locked");
	AST_WRITE_PULSE: assert property (progWrite |=> !progWrite [*8])
		else $error("write pulses too close");
	AST_WRITE_IN_PROG: assert property (progWrite |-> $past(progMode))
		else $error("write outside programming");
	AST_PROG_NATIVE: assert property (progMode |-> nativeMode)
		else $error("programming without default timing");
	AST_LOCK_READ: assert property (arrayLockFlag [*3] |-> !nativeMode && cfgWord[11])
		else $error("locked tag not in read mode");
	AST_FSK_LOW_RUN: assert property (progMode |-> dampRun <= 4'h4)
		else $error("damped run too long for low level");
	AST_LOCK_ON_EXIT: assert property (sFieldDrop |-> ##[1:3] arrayLockFlag)
		else $error("lock not set on field loss");
endmodule : lfre_tag_properties
bind lfre_tag lfre_tag_properties chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.factoryCfg(factoryCfg), .fieldPresent(fieldPresent), .arrayAddr(arrayAddr),
	.arrayData(arrayData), .progWrite(progWrite), .progData(progData), .rxBit(rxBit),
	.dampSwitch(dampSwitch), .cfgWord(cfgWord), .arrayLockFlag(arrayLockFlag),
	.nativeMode(nativeMode), .progMode(progMode));

// ---- dv/lfre_array_model.sv ----
// Purpose: Array stand-in beside the tag
// Assumes: A blank array holds all ones
// Notes:   Read data returns combinationally
`timescale 1ns/1ns
module lfre_array_model (
	// Clock
	input  wire logic       ref_clk,
	// Array port
	input  wire logic [6:0] arrayAddr,
	input  wire logic       progWrite,
	input  wire logic       progData,
	output logic            arrayData,
	// Count of writes seen
	output int              writeCnt
);
	logic mem [0:127]; // Cell per stream bit
	// Blank cells read as one
	initial begin
		foreach (mem[i]) mem[i] = 1'b1;
		writeCnt = 0;
	end
	assign arrayData = mem[arrayAddr];
	// Store each write pulse
	always @(posedge ref_clk) begin
		if (progWrite === 1'b1) begin
			mem[arrayAddr] <= progData;
			writeCnt <= writeCnt + 1;
		end
	end
endmodule : lfre_array_model

// ---- dv/tb.sv ----
// Purpose: Blank check, programming, lock and read-out of the tag
// Assumes: Reader bits come from rxBit, field from fieldPresent
// Notes:   Waits are bounded; expectations come from the option tables
`timescale 1ns/1ns
module tb;
	import lfre_pkg::*;
	logic        refClk = 1'b0; // Carrier clock
	logic        resetN;        // Power-on reset
	logic [11:0] factoryCfg;    // Factory word
	logic        fieldPresent;  // Reader field on
	logic        rxBit;         // Reader programming bit
	logic [6:0]  arrayAddr;
	logic        arrayData, progWrite, progData, dampSwitch;
	logic [11:0] cfgWord;
	logic        arrayLockFlag, nativeMode, progMode;
	int          writeCnt, errorCnt = 0, numChecks = 0, hi, lo, n;
	logic [6:0]  a;
	always #2 refClk = ~refClk;
	lfre_tag uut (.ref_clk(refClk), .reset_n(resetN), .factoryCfg(factoryCfg),
		.fieldPresent(fieldPresent), .arrayAddr(arrayAddr), .arrayData(arrayData),
		.progWrite(progWrite), .progData(progData), .rxBit(rxBit),
		.dampSwitch(dampSwitch), .cfgWord(cfgWord), .arrayLockFlag(arrayLockFlag),
		.nativeMode(nativeMode), .progMode(progMode));
	lfre_array_model model (.ref_clk(refClk), .arrayAddr(arrayAddr),
		.progWrite(progWrite), .progData(progData), .arrayData(arrayData),
		.writeCnt(writeCnt));
	// Reader sends the inverse of the address parity: a message stored once
	always @(posedge refClk) rxBit <= ~arrayAddr[0];
	task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Longest damped and undamped runs over n cycles
	task runs(input int cnt);
		int h, l;
		h = 0; l = 0; hi = 0; lo = 0;
		repeat (cnt) begin
			@(negedge refClk);
			if (dampSwitch === 1'b1) begin h++; l = 0; end
			else begin l++; h = 0; end
			if (h > hi) hi = h;
			if (l > lo) lo = l;
		end
	endtask : runs
	task gap;
		@(posedge refClk) fieldPresent <= 1'b0;
		repeat (16) @(posedge refClk);
		fieldPresent <= 1'b1;
	endtask : gap
	task stopTest;
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stopTest
	// Watchdog well past the expected run
	initial begin
		repeat (70000) @(posedge refClk);
		errorCnt++;
		stopTest();
	end
	initial begin
		resetN       = 1'b0;
		factoryCfg   = 12'h58d;
		fieldPresent = 1'b1;
		repeat (2) @(posedge refClk);
		resetN <= 1'b1;
		repeat (4) @(negedge refClk);
		check("native", {11'h0, nativeMode}, 12'h1);
		check("cfgWord", cfgWord, 12'h18d);
		gap();
		repeat (40) @(posedge refClk);
		runs(1000);
		check("one damped run", 12'(hi), 12'h5);
		check("one undamped run", 12'(lo), 12'h5);
		for (int i = 0; i < 20000 && progMode !== 1'b1; i++) @(negedge refClk);
		check("prog entered", {11'h0, progMode}, 12'h1);
		runs(1000);
		check("zero undamped run", 12'(lo), 12'h4);
		check("zero damped run", 12'(hi), 12'h4);
		for (int i = 0; i < 20000 && progMode !== 1'b0; i++) @(negedge refClk);
		check("writes", 12'(writeCnt), 12'h80);
		foreach (model.mem[i]) check("cell", {11'h0, model.mem[i]}, {11'h0, ~i[0]});
		// Reader lets the echo run, then pulls the field early in the repeat pass
		for (int i = 0; i < 20000 && progMode !== 1'b1; i++) @(negedge refClk);
		check("repeat pass", {11'h0, progMode}, 12'h1);
		repeat (60) @(posedge refClk);
		fieldPresent <= 1'b0;
		repeat (6) @(negedge refClk);
		check("lock", {11'h0, arrayLockFlag}, 12'h1);
		check("locked cfgWord", cfgWord, 12'h98d);
		check("read mode", {11'h0, nativeMode}, 12'h0);
		gap();
		repeat (400) @(negedge refClk);
		check("no reprogram", {11'h0, progMode}, 12'h0);
		a = arrayAddr;
		for (int i = 0; i < 300 && arrayAddr === a; i++) @(negedge refClk);
		a = arrayAddr;
		for (n = 0; n < 300 && arrayAddr === a; n++) @(negedge refClk);
		check("bit period", 12'(n), 12'h20);
		for (int i = 0; i < 6000 && arrayAddr !== 7'h7f; i++) @(negedge refClk);
		for (int i = 0; i < 300 && arrayAddr === 7'h7f; i++) @(negedge refClk);
		check("wrap address", {5'h0, arrayAddr}, 12'h0);
		check("writes after lock", 12'(writeCnt), 12'h80);
		// Second power-on with a locked word: ASK, Manchester, 40 cycles, 96 bits
		@(posedge refClk);
		resetN     <= 1'b0;
		factoryCfg <= 12'h8c8;
		repeat (2) @(posedge refClk);
		resetN <= 1'b1;
		repeat (4) @(negedge refClk);
		check("locked at power-on", {11'h0, arrayLockFlag}, 12'h1);
		check("read at power-on", {11'h0, nativeMode}, 12'h0);
		gap(); // A locked tag must not take this as a blank check
		a = arrayAddr;
		for (int i = 0; i < 300 && arrayAddr === a; i++) @(negedge refClk);
		a = arrayAddr;
		for (n = 0; n < 300 && arrayAddr === a; n++) @(negedge refClk);
		check("forty period", 12'(n), 12'h28);
		// Switch follows data for cycles 5..24 of the bit, its inverse after
		a = arrayAddr;
		repeat (23) @(negedge refClk);
		check("first half", {11'h0, dampSwitch}, {11'h0, ~a[0]});
		@(negedge refClk);
		check("second half", {11'h0, dampSwitch}, {11'h0, a[0]});
		for (int i = 0; i < 6000 && arrayAddr !== 7'h5f; i++) @(negedge refClk);
		for (int i = 0; i < 300 && arrayAddr === 7'h5f; i++) @(negedge refClk);
		check("short wrap", {5'h0, arrayAddr}, 12'h0);
		stopTest();
	end
endmodule : tb
